// >>> logic/sra_pkg.sv
// Overview of operation
// - auto increment set: burst; clear: single byte
// - control byte page field selects register page
// - second byte is register address in page
// - byte count field is eight bits wide
// - length mode: use byte count, ignore increment
// - read byte n comes from start plus n
// - write byte n goes to start plus n
// - polarity 0: clock idles low
// - phase 0: sample data on leading edge
// - rw polarity 0: flag 1 read, 0 write
// - length mode enabled after reset
// - third byte is byte count in length mode
// - select low starts, select high ends frame
// - rw bit 7, increment bit 6, page 1:0
// - data out low while select high
// - select rise aborts, full write bytes kept
package sra_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SCK_MIN_PERIOD_PS = 38400;
  localparam int SCK_MIN_HALF_CYC = (SCK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_MARGIN_CYC = 8;
  localparam int SCK_HALF_CYC = (SCK_MIN_HALF_CYC > SYNC_MARGIN_CYC) ?
    SCK_MIN_HALF_CYC : SYNC_MARGIN_CYC;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);
  // ----------------------------------------------------------------
  // control byte layout
  // ----------------------------------------------------------------
  localparam int CB_RW_BIT = 7;
  localparam int CB_AI_BIT = 6;
  localparam int CB_PAGE_MSB = 1;
  localparam int CB_PAGE_LSB = 0;
  // ----------------------------------------------------------------
  // device configuration reset values
  // ----------------------------------------------------------------
  localparam logic CPOL_RST = 1'b0;
  localparam logic CPHA_RST = 1'b0;
  localparam logic RWPOL_RST = 1'b0;
  localparam logic LEN_EN_RST = 1'b1;
  // ----------------------------------------------------------------
  // controller apb registers
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] HDR_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam int CT_START = 0;
  localparam int CT_CPOL = 1;
  localparam int CT_CPHA = 2;
  localparam int CT_RWPOL = 3;
  localparam int CT_LEN = 4;
  localparam int CT_READ = 5;
  localparam int CT_AI = 6;
  localparam logic [6:0] CTRL_RST = 7'h10;
  localparam int HD_ADDR_LSB = 0;
  localparam int HD_CNT_LSB = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TXV = 2;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_CTRL = 3'b000,
    DS_ADDR = 3'b001,
    DS_LEN = 3'b010,
    DS_DATA = 3'b011,
    DS_WAIT = 3'b100
  } sra_dev_state_type;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LEAD = 3'b001,
    HS_BIT0 = 3'b010,
    HS_BIT1 = 3'b011,
    HS_HOLD = 3'b100,
    HS_TAIL = 3'b101
  } sra_host_state_type;
endpackage

// >>> logic/sra_if.sv
`timescale 1ns/10ps
interface sra_if;
  logic ssel_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport device (input ssel_n, input sclk, input mosi, output miso);
  modport host (output ssel_n, output sclk, output mosi, input miso);
endinterface

// >>> logic/sra_sync.sv
`timescale 1ns/10ps
module sra_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule // sra_sync

// >>> logic/sra_device.sv
`timescale 1ns/10ps
module sra_device (
  // link
  sra_if.device link,
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic cfg_load,
  input wire logic clock_polarity_cfg,
  input wire logic clock_phase_cfg,
  input wire logic rw_flag_polarity_cfg,
  input wire logic length_field_enable,
  // register space read
  output logic [9:0] rd_addr,
  input wire logic [7:0] rd_data,
  // register space write
  output logic [9:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_en
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic ssel_n_s;
  logic sclk_s;
  logic mosi_s;

  sra_sync #(.WIDTH(3), .RST_VAL(3'h4)) sra_sync_i (
    .clk(clk),
    .rst(rst),
    .din({link.ssel_n, link.sclk, link.mosi}),
    .dout(pins_s)
  );

  assign ssel_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[0];

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  logic cpol_reg;
  logic cpha_reg;
  logic rwpol_reg;
  logic len_en_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cpol_reg <= sra_pkg::CPOL_RST;
      cpha_reg <= sra_pkg::CPHA_RST;
      rwpol_reg <= sra_pkg::RWPOL_RST;
      len_en_reg <= sra_pkg::LEN_EN_RST;
    end
    else if (cfg_load)
    begin
      cpol_reg <= clock_polarity_cfg;
      cpha_reg <= clock_phase_cfg;
      rwpol_reg <= rw_flag_polarity_cfg;
      len_en_reg <= length_field_enable;
    end
  end

  // ----------------------------------------------------------------
  // clock edges
  // ----------------------------------------------------------------
  logic sclk_prev_reg;
  logic eff_now;
  logic eff_prev;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  logic active;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sclk_prev_reg <= 1'b0;
    else
      sclk_prev_reg <= sclk_s;
  end

  assign eff_now = sclk_s ^ cpol_reg;
  assign eff_prev = sclk_prev_reg ^ cpol_reg;
  assign lead_edge = eff_now & ~eff_prev;
  assign trail_edge = ~eff_now & eff_prev;
  assign sample_edge = cpha_reg ? trail_edge : lead_edge;
  assign shift_edge = cpha_reg ? lead_edge : trail_edge;
  assign active = ~ssel_n_s;

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  logic [7:0] rx_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_byte;
  logic byte_done;

  assign rx_byte = {rx_reg[6:0], mosi_s};
  assign byte_done = active & sample_edge & (bit_cnt_reg == 3'h7);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end
    else if (!active)
      bit_cnt_reg <= 3'h0;
    else if (sample_edge)
    begin
      rx_reg <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  sra_pkg::sra_dev_state_type state_reg;
  logic [7:0] ctrl_reg;
  logic [9:0] addr_reg;
  logic [7:0] left_reg;
  logic unlim_reg;
  logic read_op;
  logic in_data;

  assign read_op = ctrl_reg[sra_pkg::CB_RW_BIT] ^ rwpol_reg;
  assign in_data = (state_reg == sra_pkg::DS_DATA);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= sra_pkg::DS_CTRL;
      ctrl_reg <= 8'h00;
      left_reg <= 8'h00;
      unlim_reg <= 1'b0;
    end
    else if (!active)
      state_reg <= sra_pkg::DS_CTRL;
    else if (byte_done)
    begin
      case (state_reg)
        sra_pkg::DS_CTRL:
        begin
          ctrl_reg <= rx_byte;
          state_reg <= sra_pkg::DS_ADDR;
        end
        sra_pkg::DS_ADDR:
        begin
          if (len_en_reg)
            state_reg <= sra_pkg::DS_LEN;
          else
          begin
            unlim_reg <= ctrl_reg[sra_pkg::CB_AI_BIT];
            left_reg <= 8'h01;
            state_reg <= sra_pkg::DS_DATA;
          end
        end
        sra_pkg::DS_LEN:
        begin
          unlim_reg <= 1'b0;
          left_reg <= rx_byte;
          state_reg <= (rx_byte == 8'h00) ? sra_pkg::DS_WAIT : sra_pkg::DS_DATA;
        end
        sra_pkg::DS_DATA:
        begin
          left_reg <= left_reg - 8'h01;
          if (!unlim_reg && (left_reg == 8'h01))
            state_reg <= sra_pkg::DS_WAIT;
        end
        sra_pkg::DS_WAIT:
          state_reg <= sra_pkg::DS_WAIT;
        default:
          state_reg <= sra_pkg::DS_CTRL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register address
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      addr_reg <= 10'h000;
    else if (byte_done && (state_reg == sra_pkg::DS_ADDR))
      addr_reg <= {ctrl_reg[sra_pkg::CB_PAGE_MSB:sra_pkg::CB_PAGE_LSB], rx_byte};
    else if (byte_done && in_data)
      addr_reg <= addr_reg + 10'h001;
  end

  assign rd_addr = addr_reg;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_en <= 1'b0;
      wr_addr <= 10'h000;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_en <= byte_done & in_data & ~read_op;
      if (byte_done && in_data && !read_op)
      begin
        wr_addr <= addr_reg;
        wr_data <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  logic [7:0] tx_reg;
  logic [7:0] tx_load;

  assign tx_load = (in_data && read_op) ? rd_data : 8'h00;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_reg <= 8'h00;
    else if (!active)
      tx_reg <= 8'h00;
    else if (shift_edge)
    begin
      if (bit_cnt_reg == 3'h0)
        tx_reg <= tx_load;
      else
        tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  assign link.miso = tx_reg[7];
endmodule // sra_device

// >>> logic/sra_host.sv
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
module sra_host (
  // link
  sra_if.host link,
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] decode(input logic [7:0] a);
    decode = {a == sra_pkg::STAT_OFS, a == sra_pkg::DATA_OFS,
              a == sra_pkg::HDR_OFS, a == sra_pkg::CTRL_OFS};
  endfunction

  logic [3:0] wsel;
  logic wr_en;
  logic setup;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign wsel = wr_en ? decode(paddr) : 4'h0;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  sra_pkg::sra_host_state_type state_reg;
  logic [6:0] ctrl_reg;
  logic [9:0] addr_reg;
  logic [7:0] cnt_reg;
  logic [7:0] txd_reg;
  logic [7:0] rxd_reg;
  logic txv_reg;
  logic done_reg;
  logic [3:0] tim_reg;
  logic start;
  logic consume;
  logic byte_end;
  logic busy;
  logic [2:0] bit_reg;
  logic [1:0] idx_reg;

  assign busy = (state_reg != sra_pkg::HS_IDLE);
  assign start = wsel[0] & pwdata[sra_pkg::CT_START] & ~busy & (tim_reg == 4'h0);
  assign consume = (state_reg == sra_pkg::HS_HOLD) & txv_reg;
  assign byte_end = (state_reg == sra_pkg::HS_BIT1) & (tim_reg == 4'h0) & (bit_reg == 3'h7);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= sra_pkg::CTRL_RST;
      addr_reg <= 10'h000;
      cnt_reg <= 8'h00;
      txd_reg <= 8'h00;
    end
    else
    begin
      if (wsel[0])
        ctrl_reg <= {pwdata[sra_pkg::CT_AI:sra_pkg::CT_CPOL], 1'b0};
      if (wsel[1])
      begin
        addr_reg <= pwdata[sra_pkg::HD_ADDR_LSB +: 10];
        cnt_reg <= pwdata[sra_pkg::HD_CNT_LSB +: 8];
      end
      if (wsel[2])
        txd_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txv_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      txv_reg <= wsel[2] | (txv_reg & ~consume);
      done_reg <= (byte_end && idx_reg == 2'h3) |
                  (done_reg & ~(wsel[3] & pwdata[sra_pkg::ST_DONE]));
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & (decode(paddr) == 4'h0);
      case (decode(paddr))
        4'h1: prdata <= {25'h0, ctrl_reg};
        4'h2: prdata <= {8'h00, cnt_reg, 6'h00, addr_reg};
        4'h4: prdata <= {24'h0, rxd_reg};
        4'h8: prdata <= {29'h0, txv_reg, done_reg, busy};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link engine
  // ----------------------------------------------------------------
  logic miso_s;
  logic [7:0] sh_reg;
  logic [7:0] rx_sh;
  logic [7:0] left_reg;
  logic cpol;
  logic cpha;

  assign cpol = ctrl_reg[sra_pkg::CT_CPOL];
  assign cpha = ctrl_reg[sra_pkg::CT_CPHA];

  sra_sync #(.WIDTH(1), .RST_VAL(1'b0)) sra_sync_i (
    .clk(clk),
    .rst(rst),
    .din(link.miso),
    .dout(miso_s)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= sra_pkg::HS_IDLE;
      tim_reg <= 4'h0;
      bit_reg <= 3'h0;
      idx_reg <= 2'h0;
      sh_reg <= 8'h00;
      rx_sh <= 8'h00;
      rxd_reg <= 8'h00;
      left_reg <= 8'h00;
      link.ssel_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
    end
    else
    begin
      if (tim_reg != 4'h0)
        tim_reg <= tim_reg - 4'h1;
      case (state_reg)
        sra_pkg::HS_IDLE:
          if (start)
          begin
            link.ssel_n <= 1'b0;
            link.sclk <= pwdata[sra_pkg::CT_CPOL];
            sh_reg <= {pwdata[sra_pkg::CT_READ] ^ pwdata[sra_pkg::CT_RWPOL],
                       pwdata[sra_pkg::CT_AI], 4'h0, addr_reg[9:8]};
            left_reg <= cnt_reg;
            idx_reg <= 2'h0;
            bit_reg <= 3'h0;
            tim_reg <= sra_pkg::SCK_HALF_LAST;
            state_reg <= sra_pkg::HS_LEAD;
          end
        sra_pkg::HS_LEAD, sra_pkg::HS_HOLD:
          if ((state_reg == sra_pkg::HS_LEAD && tim_reg == 4'h0) || consume)
          begin
            if (consume)
            begin
              sh_reg <= {txd_reg[6:0], 1'b0};
              link.mosi <= txd_reg[7];
              idx_reg <= 2'h3;
            end
            else
              link.mosi <= sh_reg[7];
            link.sclk <= cpol ^ cpha;
            tim_reg <= sra_pkg::SCK_HALF_LAST;
            state_reg <= sra_pkg::HS_BIT0;
          end
        sra_pkg::HS_BIT0:
          if (tim_reg == 4'h0)
          begin
            link.sclk <= cpol ^ ~cpha;
            rx_sh <= {rx_sh[6:0], miso_s};
            if (idx_reg != 2'h3 || bit_reg != 3'h0)
              sh_reg <= {sh_reg[6:0], 1'b0};
            tim_reg <= sra_pkg::SCK_HALF_LAST;
            state_reg <= sra_pkg::HS_BIT1;
          end
        sra_pkg::HS_BIT1:
          if (tim_reg == 4'h0)
          begin
            bit_reg <= bit_reg + 3'h1;
            tim_reg <= sra_pkg::SCK_HALF_LAST;
            if (bit_reg != 3'h7)
            begin
              link.mosi <= sh_reg[7];
              link.sclk <= cpol ^ cpha;
              state_reg <= sra_pkg::HS_BIT0;
            end
            else if (idx_reg == 2'h0 || (idx_reg == 2'h1 && ctrl_reg[sra_pkg::CT_LEN]))
            begin
              sh_reg <= (idx_reg == 2'h0) ? addr_reg[7:0] : cnt_reg;
              link.mosi <= (idx_reg == 2'h0) ? addr_reg[7] : cnt_reg[7];
              link.sclk <= cpol ^ cpha;
              idx_reg <= idx_reg + 2'h1;
              state_reg <= sra_pkg::HS_BIT0;
            end
            else
            begin
              if (idx_reg == 2'h3)
              begin
                rxd_reg <= rx_sh;
                left_reg <= left_reg - 8'h01;
              end
              if ((idx_reg == 2'h3) ? (left_reg == 8'h01) : (left_reg == 8'h00))
                state_reg <= sra_pkg::HS_TAIL;
              else
                state_reg <= sra_pkg::HS_HOLD;
            end
          end
        sra_pkg::HS_TAIL:
          if (tim_reg == 4'h0)
          begin
            link.ssel_n <= 1'b1;
            tim_reg <= sra_pkg::SCK_HALF_LAST;
            state_reg <= sra_pkg::HS_IDLE;
          end
        default:
          state_reg <= sra_pkg::HS_IDLE;
      endcase
      if (state_reg == sra_pkg::HS_BIT1 && tim_reg == 4'h0 && bit_reg == 3'h7)
        if (!(idx_reg == 2'h0 || (idx_reg == 2'h1 && ctrl_reg[sra_pkg::CT_LEN])))
          link.sclk <= cpol;
    end
  end
endmodule // sra_host

// >>> tb/sra_props.sv
`timescale 1ns/10ps
module sra_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic ssel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  // device write side
  input wire logic wr_en,
  input wire logic [9:0] wr_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // burst tracking
  // ----------------------------------------------------------------
  logic seen_reg;
  logic [9:0] last_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      seen_reg <= 1'b0;
    else if (ssel_n)
      seen_reg <= 1'b0;
    else if (wr_en)
      seen_reg <= 1'b1;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      last_reg <= 10'h000;
    else if (wr_en)
      last_reg <= wr_addr;
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence high_half;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence low_lead;
    !sclk [*8];
  endsequence
  miso_idle_a: assert property (ssel_n |-> !miso)
    else $error("miso high while deselected");
  sclk_idle_a: assert property (ssel_n |-> !sclk)
    else $error("clock not idle low");
  sclk_lead_a: assert property ($fell(ssel_n) |-> low_lead)
    else $error("clock moved in select lead");
  sclk_half_a: assert property ($rose(sclk) |-> high_half)
    else $error("clock high phase wrong");
  mosi_hold_a: assert property ($rose(sclk) |-> $stable(mosi) [*8])
    else $error("data moved while clock high");
  select_gap_a: assert property ($rose(ssel_n) |-> ssel_n [*8])
    else $error("select gap too short");
  frame_write_a: assert property (wr_en |-> !ssel_n)
    else $error("write outside frame");
  write_pulse_a: assert property (wr_en |=> !wr_en [*8])
    else $error("write pulse too long");
  addr_step_a: assert property (wr_en && seen_reg |-> wr_addr == last_reg + 10'h001)
    else $error("burst address not stepped");
endmodule // sra_props

// >>> tb/sra_tb.sv
`timescale 1ns/10ps
module sra_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, rst, psel, penable, pwrite, pready, pslverr, cfg_load, len_cfg, wr_en, e, pol;
  logic [7:0] paddr, rd_data, wr_data;
  logic [31:0] pwdata, prdata, q;
  logic [9:0] rd_addr, wr_addr;
  logic [7:0] mem [1024];
  int err_count, num_checks, wr_cnt;
  sra_if link_if();
  sra_device sra_device_i (.link(link_if.device), .clk(clk), .rst(rst), .cfg_load(cfg_load),
    .clock_polarity_cfg(1'b0), .clock_phase_cfg(1'b0), .rw_flag_polarity_cfg(pol),
    .length_field_enable(len_cfg), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en));
  sra_host sra_host_i (.link(link_if.host), .clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  sra_props sra_props_i (.clk(clk), .rst(rst), .ssel_n(link_if.ssel_n), .sclk(link_if.sclk),
    .mosi(link_if.mosi), .miso(link_if.miso), .wr_en(wr_en), .wr_addr(wr_addr));
  // ----------------------------------------------------------------
  // register space model
  // ----------------------------------------------------------------
  assign rd_data = mem[rd_addr];
  always @(posedge clk)
  begin
    if (wr_en === 1'b1)
    begin
      mem[wr_addr] <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] pat(input logic [9:0] a);
    return a[7:0] ^ {6'h00, a[9:8]} ^ 8'h5a;
  endfunction
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, sra_pkg::STAT_OFS, 32'h0);
      n++;
    end
    while (q[b] !== v && n < 2000);
    chk("status poll", 32'(q[b]), 32'(v));
  endtask
  task automatic frame(input logic rd, input logic ai, input logic len, input logic [9:0] a,
    input int cnt);
    int ok, w0, i;
    ok = (len || ai) ? cnt : 1;
    w0 = wr_cnt;
    apb(1'b1, sra_pkg::HDR_OFS, {8'h00, 8'(cnt), 6'h00, a});
    apb(1'b1, sra_pkg::CTRL_OFS, {25'h0, ai, rd, len, pol, 2'b00, 1'b1});
    for (i = 0; i < cnt; i++)
    begin
      apb(1'b1, sra_pkg::DATA_OFS, 32'(8'ha0 + 8'(i)));
      poll(sra_pkg::ST_TXV, 1'b0);
      if (rd && i > 0)
      begin
        apb(1'b0, sra_pkg::DATA_OFS, 32'h0);
        chk("read byte", 32'(q[7:0]), (i - 1 < ok) ? 32'(pat(a + 10'(i - 1))) : 32'h0);
      end
    end
    poll(sra_pkg::ST_BUSY, 1'b0);
    poll(sra_pkg::ST_DONE, 1'b1);
    apb(1'b1, sra_pkg::STAT_OFS, 32'h1 << sra_pkg::ST_DONE);
    apb(1'b0, sra_pkg::STAT_OFS, 32'h0);
    chk("done clear", 32'(q[sra_pkg::ST_DONE]), 32'h0);
    if (rd)
    begin
      apb(1'b0, sra_pkg::DATA_OFS, 32'h0);
      chk("last read byte", 32'(q[7:0]),
        (cnt - 1 < ok) ? 32'(pat(a + 10'(cnt - 1))) : 32'h0);
    end
    for (i = 0; i < cnt && !rd; i++)
      chk("write byte", 32'(mem[a + 10'(i)]),
        (i < ok) ? 32'(8'ha0 + 8'(i)) : 32'(pat(a + 10'(i))));
    chk("write count", 32'(wr_cnt - w0), rd ? 32'h0 : 32'(ok));
    repeat (16) @(posedge clk);
    $display("frame at %h done", a);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg_load = 1'b0;
    len_cfg = 1'b1;
    pol = 1'b0;
    for (int k = 0; k < 1024; k++)
      mem[k] = pat(10'(k));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, sra_pkg::CTRL_OFS, 32'h0);
    chk("ctrl reset", q, 32'(sra_pkg::CTRL_RST));
    chk("miso idle", 32'(link_if.miso), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'(e), 32'h1);
    $display("reset test done");
    frame(1'b0, 1'b0, 1'b1, 10'h2fe, 3);
    frame(1'b1, 1'b1, 1'b1, 10'h110, 3);
    cfg_load <= 1'b1;
    len_cfg <= 1'b0;
    @(posedge clk);
    cfg_load <= 1'b0;
    frame(1'b0, 1'b0, 1'b0, 10'h040, 2);
    frame(1'b0, 1'b1, 1'b0, 10'h080, 2);
    frame(1'b1, 1'b0, 1'b0, 10'h0c0, 2);
    pol <= 1'b1;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    frame(1'b0, 1'b1, 1'b0, 10'h3f0, 2);
    frame(1'b1, 1'b0, 1'b0, 10'h1c0, 2);
    final_report;
  end
  initial
  begin
    wr_cnt = 0;
    #400000;
    err_count++;
    final_report;
  end
endmodule // sra_tb
